// ===== osd_params.svh
`ifndef OSD_PARAMS_SVH
`define OSD_PARAMS_SVH
`define OSD_ADDR_STATUS 8'h10
`define OSD_ADDR_CFG 8'h11
`define OSD_ADDR_COUNT 8'h12
`define OSD_STATUS_RESET 8'h00
`define OSD_CFG_RESET 8'h80
`define OSD_COUNT_RESET 8'h00
`define OSD_BIT_CHANGE 7
`define OSD_BIT_LOCKOUT 6
`define OSD_BIT_TILT_HI 2
`define OSD_BIT_TILT_LO 1
`define OSD_BIT_FACE 0
`define OSD_BIT_DBMODE 7
`define OSD_BIT_ENABLE 6
`define OSD_HOLD_LIMIT 14'h1400
`define OSD_LOCK_LIMIT 14'h0800
`endif

// ===== osd_pkg.sv
package osd_pkg;
  typedef enum logic [1:0] {
    OSD_PORTRAIT_UP = 2'h0,
    OSD_PORTRAIT_DOWN = 2'h1,
    OSD_LANDSCAPE_RIGHT = 2'h2,
    OSD_LANDSCAPE_LEFT = 2'h3
  } osd_tilt_t;
  typedef struct packed {
    logic lockout;
    osd_tilt_t tilt;
    logic face;
  } osd_orient_t;
  typedef struct packed {
    logic signed [13:0] x;
    logic signed [13:0] y;
    logic signed [13:0] z;
  } osd_sample_t;
  typedef enum logic [0:0] {
    OSD_IDLE,
    OSD_RUN
  } osd_state_t;
endpackage

// ===== osd_classifier.sv
`timescale 1ns/1ps
`default_nettype none
`include "osd_params.svh"
module osd_classifier
  import osd_pkg::*;
(
  input wire osd_sample_t sample_i,
  input wire logic [13:0] lock_limit_i,
  output osd_orient_t orient_o,
  output logic overload_o
);
  function automatic logic [13:0] osd_abs(input logic signed [13:0] v);
    osd_abs = v[13] ? 14'(-v) : 14'(v);
  endfunction
  logic [13:0] ax;
  logic [13:0] ay;
  logic [13:0] az;
  always_comb begin
    ax = osd_abs(sample_i.x);
    ay = osd_abs(sample_i.y);
    az = osd_abs(sample_i.z);
    // any axis above the hold limit freezes the result
    overload_o = (ax > `OSD_HOLD_LIMIT) || (ay > `OSD_HOLD_LIMIT) ||
                 (az > `OSD_HOLD_LIMIT);
    orient_o.face = sample_i.z[13];
    // lockout when the larger in-plane axis is below the lock limit
    orient_o.lockout = ((ax > ay) ? ax : ay) < lock_limit_i;
    if (ay >= ax) begin
      orient_o.tilt = sample_i.y[13] ? OSD_PORTRAIT_DOWN : OSD_PORTRAIT_UP;
    end else begin
      orient_o.tilt = sample_i.x[13] ? OSD_LANDSCAPE_LEFT : OSD_LANDSCAPE_RIGHT;
    end
  end
endmodule
`default_nettype wire

// ===== osd_top.sv
// Functional notes
// - classify into portrait up/down, landscape left/right with lockout, face up/down.
// - set change flag bit 7 when face, tilt code or lockout changes.
// - set change flag after first detection following standby to active.
// - reading status clears change flag and the orientation interrupt.
// - orientation fields keep updating while change flag is set.
// - lockout bit is 1 when z-tilt trip angle is exceeded, else 0.
// - tilt code 00 up, 01 down, 10 landscape right, 11 landscape left.
// - bit 0 shows face side, 0 front, 1 back.
// - hold orientation while any axis exceeds 1.25 g.
// - at power-up face and tilt undefined, lockout inactive.
// - detection runs only while enable bit is 1.
// - on lost condition debounce decrements in mode 0, clears in mode 1.
// - accept transition only after debounce reaches programmed count.
// - rate change or active/standby change resets debounce counters.
`timescale 1ns/1ps
`default_nettype none
`include "osd_params.svh"
module osd_top
  import osd_pkg::*;
#(
  parameter logic [13:0] LOCK_LIMIT = `OSD_LOCK_LIMIT
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic active_i,
  input wire logic rate_change_i,
  input wire logic sample_valid_i,
  input wire osd_sample_t sample_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic orient_irq_o
);
  osd_orient_t raw;
  logic overload;
  osd_classifier u_class (
    .sample_i(sample_i),
    .lock_limit_i(LOCK_LIMIT),
    .orient_o(raw),
    .overload_o(overload)
  );

  logic [7:0] cfg;
  logic [7:0] debounce_limit;
  osd_orient_t current;
  osd_orient_t candidate;
  logic change_flag;
  logic [7:0] count;
  logic first_pending;
  logic active_d;
  osd_state_t state;
  logic [7:0] next_cfg;
  logic [7:0] next_debounce_limit;
  osd_orient_t next_current;
  osd_orient_t next_candidate;
  logic next_change_flag;
  logic [7:0] next_count;
  logic next_first_pending;
  osd_state_t next_state;
  logic [7:0] next_rdata;
  logic enable;
  logic dbmode;
  logic status_read;
  logic set_event;
  logic cfg_write;
  logic count_write;
  logic active_edge;
  logic run_ok;
  logic sample_take;
  logic limit_reached;

  // one address compare shared by the write strobes and the read-clear
  function automatic logic osd_hit(input logic [7:0] addr, input logic [7:0] target);
    osd_hit = (addr == target);
  endfunction

  // one packing for the read path, keeps spare bits 5:3 at zero
  function automatic logic [7:0] osd_status_word(input logic flag, input osd_orient_t o);
    osd_status_word = {flag, o.lockout, 3'h0, o.tilt, o.face};
  endfunction

  always_comb begin
    enable = cfg[`OSD_BIT_ENABLE];
    dbmode = cfg[`OSD_BIT_DBMODE];
    status_read = reg_rd_i && osd_hit(reg_addr_i, `OSD_ADDR_STATUS);
    cfg_write = reg_wr_i && osd_hit(reg_addr_i, `OSD_ADDR_CFG);
    count_write = reg_wr_i && osd_hit(reg_addr_i, `OSD_ADDR_COUNT);
    next_cfg = cfg;
    next_debounce_limit = debounce_limit;
    // the status register has no writable bits, so writes to it fall through
    if (cfg_write) begin
      next_cfg = reg_wdata_i;
    end
    if (count_write) begin
      next_debounce_limit = reg_wdata_i;
    end
    // unmapped addresses read as zero
    next_rdata = 8'h00;
    unique case (reg_addr_i)
      `OSD_ADDR_STATUS: next_rdata = osd_status_word(change_flag, current);
      `OSD_ADDR_CFG: next_rdata = cfg;
      `OSD_ADDR_COUNT: next_rdata = debounce_limit;
      default: next_rdata = 8'h00;
    endcase
    if (!reg_rd_i) begin
      next_rdata = reg_rdata_o;
    end
  end

  always_comb begin
    active_edge = (active_i != active_d);
    run_ok = active_i && enable;
    sample_take = sample_valid_i && !overload;
    limit_reached = (count >= debounce_limit);
    next_current = current;
    next_candidate = candidate;
    next_count = count;
    next_first_pending = first_pending;
    next_state = state;
    set_event = 1'b0;
    unique case (state)
      OSD_IDLE: begin
        // a disabled block drops samples; the counter restarts on enable
        if (run_ok) begin
          next_state = OSD_RUN;
          next_count = 8'h00;
        end
      end
      OSD_RUN: begin
        if (!run_ok) begin
          next_state = OSD_IDLE;
        end else if (sample_take) begin
          // overloaded samples neither advance nor restart the debounce
          if (first_pending) begin
            next_current = raw;
            next_candidate = raw;
            next_first_pending = 1'b0;
            set_event = 1'b1;
          end else if (raw != current) begin
            // a differing result must repeat until the count reaches the limit to replace current
            if (raw != candidate) begin
              next_candidate = raw;
              next_count = 8'h00;
            end else if (limit_reached) begin
              next_current = raw;
              next_count = 8'h00;
              set_event = 1'b1;
            end else begin
              next_count = 8'(count + 8'h01);
            end
          end else if (dbmode) begin
            next_count = 8'h00;
          end else if (count != 8'h00) begin
            next_count = 8'(count - 8'h01);
          end
        end
      end
    endcase
    // standby/active change or rate change restarts debounce
    if (active_edge || rate_change_i) begin
      next_count = 8'h00;
    end
    if (active_i && !active_d) begin
      next_first_pending = 1'b1;
    end
  end

  // register group: config and read data stand until rewritten or reread
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= `OSD_CFG_RESET;
      debounce_limit <= `OSD_COUNT_RESET;
      reg_rdata_o <= 8'h00;
    end else begin
      cfg <= next_cfg;
      debounce_limit <= next_debounce_limit;
      reg_rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // lockout inactive; face and tilt carry no meaning until the first detection
      current <= '0;
      candidate <= '0;
      count <= 8'h00;
      // a reset counts as entering active, so the first result is always flagged
      first_pending <= 1'b1;
      active_d <= 1'b0;
      state <= OSD_IDLE;
    end else begin
      current <= next_current;
      candidate <= next_candidate;
      count <= next_count;
      first_pending <= next_first_pending;
      active_d <= active_i;
      state <= next_state;
    end
  end

  // flag group: the set from detection and the clear from a status read meet here
  always_comb begin
    // a new event in the read cycle survives the clear, so no change is lost
    next_change_flag = set_event ? 1'b1 : (status_read ? 1'b0 : change_flag);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      change_flag <= 1'b0;
    end else begin
      change_flag <= next_change_flag;
    end
  end

  // the interrupt is the flag itself, so the read that clears one clears both
  assign orient_irq_o = change_flag;
endmodule
`default_nettype wire

// ===== osd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module osd_host_model (
  input wire logic clock_i,
  output logic [7:0] reg_addr_o = 8'h00,
  output logic reg_wr_o = 1'b0,
  output logic reg_rd_o = 1'b0,
  output logic [7:0] reg_wdata_o = 8'h00,
  input wire logic [7:0] reg_rdata_i
);
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} <= {a, v, 1'b1};
    @(posedge clock_i);
    // released data must not keep looking valid
    {reg_wdata_o, reg_wr_o} <= {~v, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    {reg_addr_o, reg_rd_o} <= {a, 1'b1};
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    #1 v = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ===== osd_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module osd_top_sva
  import osd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic active_i,
  input wire logic sample_valid_i,
  input wire osd_sample_t sample_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic orient_irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic st_rd;
  assign st_rd = reg_rd_i && (reg_addr_i == 8'h10);
  property p_flag; st_rd |=> reg_rdata_o[7] == $past(orient_irq_o); endproperty
  a_flag: assert property (p_flag) else $error("flag bit differs from irq");
  property p_clr; st_rd && !sample_valid_i && !$past(sample_valid_i) |=> !orient_irq_o; endproperty
  a_clr: assert property (p_clr) else $error("status read left irq set");
  property p_rise; $rose(orient_irq_o) |-> $past(sample_valid_i) || $past(sample_valid_i, 2); endproperty
  a_rise: assert property (p_rise) else $error("irq rose without sample");
  property p_fall; $fell(orient_irq_o) |-> $past(st_rd); endproperty
  a_fall: assert property (p_fall) else $error("irq fell without read");
  property p_rsv; st_rd |=> reg_rdata_o[5:3] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("status spare bits set");
  property p_stand; !$past(reg_rd_i) |-> $stable(reg_rdata_o); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_idle; !active_i && !$past(active_i) |-> !$rose(orient_irq_o); endproperty
  a_idle: assert property (p_idle) else $error("irq rose in standby");
  property p_over; sample_valid_i && sample_i.x > 14'sh1400 && !orient_irq_o |=> !orient_irq_o [*2];
  endproperty
  a_over: assert property (p_over) else $error("overload sample changed state");
endmodule
bind osd_top osd_top_sva osd_top_sva_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .active_i(active_i),
  .sample_valid_i(sample_valid_i), .sample_i(sample_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .orient_irq_o(orient_irq_o));
`default_nettype wire

// ===== tb_orientation_status_detector.sv
`timescale 1ns/1ps
`default_nettype none
module tb_orientation_status_detector;
  import osd_pkg::*;
  typedef struct packed {
    osd_sample_t s;
    logic [7:0] st;
  } osd_row_t;
  localparam logic signed [13:0] g1 = 14'sh1000;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic active_i = 1'b0;
  logic rate_change_i = 1'b0;
  logic sample_valid_i = 1'b0;
  osd_sample_t sample_i = '0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, orient_irq;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [7:0] ra [4] = '{8'h10, 8'h11, 8'h12, 8'h20};
  logic [7:0] re [4] = '{8'h00, 8'h80, 8'h00, 8'h00};
  osd_row_t rows [5] = '{'{'{14'sh0000, g1, 14'sh0800}, 8'h00},
    '{'{14'sh0000, -g1, 14'sh0800}, 8'h02},
    '{'{g1, 14'sh0000, 14'sh0800}, 8'h04},
    '{'{-g1, 14'sh0000, -14'sh0800}, 8'h07},
    '{'{14'sh0000, 14'sh0100, g1}, 8'h40}};
  always #12.5 clock_i = ~clock_i;
  osd_top osd_top_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .active_i(active_i),
    .rate_change_i(rate_change_i), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .orient_irq_o(orient_irq));
  osd_host_model osd_host_model_i (.clock_i(clock_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic smp(input osd_sample_t s, input int k);
    repeat (k) begin
      @(posedge clock_i);
      {sample_i, sample_valid_i} <= {s, 1'b1};
      @(posedge clock_i);
      sample_valid_i <= 1'b0;
      repeat (2) @(posedge clock_i);
    end
  endtask
  task automatic pulse_rate();
    @(posedge clock_i);
    rate_change_i <= 1'b1;
    @(posedge clock_i);
    rate_change_i <= 1'b0;
  endtask
  task automatic st(input logic [7:0] e);
    osd_host_model_i.rd(8'h10, d);
    chk("status", e, d);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    foreach (ra[i]) begin
      osd_host_model_i.rd(ra[i], d);
      chk("reset_reg", re[i], d);
    end
    $display("end reset");
    @(posedge clock_i) active_i <= 1'b1;
    osd_host_model_i.wr(8'h11, 8'hc0);
    foreach (rows[i]) begin
      smp(rows[i].s, 2);
      st(8'h80 | rows[i].st);
      st(rows[i].st);
      chk("irq", 8'h00, {7'h00, orient_irq});
    end
    $display("end table");
    smp(rows[0].s, 2);
    smp(rows[1].s, 2);
    st(8'h82);
    smp('{14'sh1401, 14'sh0000, 14'sh0800}, 2);
    st(8'h02);
    $display("end update and overload");
    // limit 2: the rate clear moves acceptance from the fourth sample to the fifth
    osd_host_model_i.wr(8'h12, 8'h02);
    smp(rows[2].s, 2);
    pulse_rate();
    smp(rows[2].s, 2);
    st(8'h02);
    smp(rows[2].s, 1);
    st(8'h84);
    // clear mode: one lost sample restarts the count, so b b b a b b is not enough
    smp(rows[3].s, 3);
    smp(rows[2].s, 1);
    smp(rows[3].s, 2);
    st(8'h04);
    // decrement mode: the lost sample only steps back, so b b a b b accepts
    osd_host_model_i.wr(8'h11, 8'h40);
    pulse_rate();
    smp(rows[3].s, 2);
    smp(rows[2].s, 1);
    smp(rows[3].s, 2);
    st(8'h87);
    $display("end debounce");
    @(posedge clock_i) active_i <= 1'b0;
    smp(rows[3].s, 1);
    active_i <= 1'b1;
    smp(rows[3].s, 1);
    st(8'h87);
    osd_host_model_i.wr(8'h11, 8'h80);
    osd_host_model_i.wr(8'h10, 8'hff);
    smp(rows[0].s, 4);
    st(8'h07);
    $display("end standby and disable");
    tally_and_finish();
  end
endmodule
`default_nettype wire
